/* File: rtl/cfr_map.svh */
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH
// =====================================
// flag bit positions
`define CFR_CF_BIT 0
`define CFR_RSV1_BIT 1
`define CFR_PF_BIT 2
`define CFR_AF_BIT 4
`define CFR_ZF_BIT 6
`define CFR_SF_BIT 7
`define CFR_TF_BIT 8
`define CFR_IF_BIT 9
`define CFR_DF_BIT 10
`define CFR_OF_BIT 11
`define CFR_IO_PRIVILEGE_LEVEL_LO 12
`define CFR_IO_PRIVILEGE_LEVEL_HI 13
`define CFR_NT_BIT 14
`define CFR_RF_BIT 16
`define CFR_VM_BIT 17
`define CFR_AC_BIT 18
`define CFR_VIF_BIT 19
`define CFR_VIP_BIT 20
`define CFR_ID_BIT 21
// =====================================
// values and masks
`define CFR_RESET_VAL 64'h0000_0000_0000_0002
`define CFR_WRITE_MASK 64'h0000_0000_003f_7fd5
`define CFR_IO_PRIVILEGE_LEVEL_MASK 64'h0000_0000_0000_3000
`define CFR_AF_SRC_BIT 4
`define CFR_CPL_KERNEL 2'h0
`define CFR_CPL_USER 2'h3
`endif

/* File: rtl/cfr_pkg.sv */
// =====================================
// shared types
package cfr_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_LOGIC,
    OP_SET_CARRY, OP_CLEAR_CARRY, OP_COMPL_CARRY, OP_BIT_TEST,
    OP_SET_DIR, OP_CLEAR_DIR, OP_FLAGS_POP, OP_INT_RETURN,
    OP_TASK_LINK, OP_TASK_UNLINK
  } cfr_op_t;
  typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32, SZ_64} cfr_size_t;
endpackage : cfr_pkg

/* File: rtl/cfr_status_calc.sv */
`timescale 1ns/1ps
`include "cfr_map.svh"
// =====================================
// arithmetic result and status flag derivation
module cfr_status_calc (
  input wire cfr_pkg::cfr_op_t op, // operation
  input wire cfr_pkg::cfr_size_t size, // operand width
  input wire logic [63:0] a, // first operand
  input wire logic [63:0] b, // second operand
  input wire logic carry_in, // current carry flag
  output logic [63:0] result, // sized result
  output logic cf, // carry or borrow out
  output logic pf, // even parity low byte
  output logic af, // nibble carry
  output logic zf, // zero result
  output logic sf, // sign
  output logic of // signed overflow
);
  // width mask per operand size
  function automatic logic [63:0] size_mask(input cfr_pkg::cfr_size_t s);
    case (s)
      cfr_pkg::SZ_8: size_mask = 64'h0000_0000_0000_00ff;
      cfr_pkg::SZ_16: size_mask = 64'h0000_0000_0000_ffff;
      cfr_pkg::SZ_32: size_mask = 64'h0000_0000_ffff_ffff;
      default: size_mask = 64'hffff_ffff_ffff_ffff;
    endcase
  endfunction : size_mask

  // pick the top bit of a value for the operand size
  function automatic logic top_bit(input logic [64:0] v, input cfr_pkg::cfr_size_t s);
    case (s)
      cfr_pkg::SZ_8: top_bit = v[7];
      cfr_pkg::SZ_16: top_bit = v[15];
      cfr_pkg::SZ_32: top_bit = v[31];
      default: top_bit = v[63];
    endcase
  endfunction : top_bit

  logic is_sub;
  logic cin;
  logic [63:0] am;
  logic [63:0] bm;
  logic [64:0] sum;

  // adder with chained carry
  always_comb begin
    is_sub = (op == cfr_pkg::OP_SUB) || (op == cfr_pkg::OP_SBB);
    am = a & size_mask(size);
    bm = (is_sub ? ~b : b) & size_mask(size);
    // RULE_09 carry chaining input
    case (op)
      cfr_pkg::OP_ADC: cin = carry_in;
      cfr_pkg::OP_SUB: cin = 1'b1;
      cfr_pkg::OP_SBB: cin = ~carry_in;
      default: cin = 1'b0;
    endcase
    if (op == cfr_pkg::OP_LOGIC) begin
      sum = {1'b0, a & b & size_mask(size)};
    end else begin
      sum = {1'b0, am} + {1'b0, bm} + {64'h0, cin};
    end
    result = sum[63:0] & size_mask(size);
  end

  // status flags
  always_comb begin
    // RULE_01 carry out of top bit
    case (size)
      cfr_pkg::SZ_8: cf = sum[8];
      cfr_pkg::SZ_16: cf = sum[16];
      cfr_pkg::SZ_32: cf = sum[32];
      default: cf = sum[64];
    endcase
    if (is_sub) begin
      cf = ~cf;
    end
    // RULE_02 even parity low byte
    pf = ~^result[7:0];
    // RULE_03 nibble carry
    af = a[`CFR_AF_SRC_BIT] ^ b[`CFR_AF_SRC_BIT] ^ result[`CFR_AF_SRC_BIT];
    // RULE_04 whole result zero
    zf = (result == 64'h0);
    // RULE_05 sign copy
    sf = top_bit({1'b0, result}, size);
    // RULE_06 two's complement overflow
    of = (top_bit({1'b0, am}, size) == top_bit({1'b0, bm}, size)) &&
         (sf != top_bit({1'b0, am}, size));
    if (op == cfr_pkg::OP_LOGIC) begin
      cf = 1'b0;
      of = 1'b0;
      af = 1'b0;
    end
  end
endmodule : cfr_status_calc

/* File: rtl/cfr_access_gate.sv */
`timescale 1ns/1ps
`include "cfr_map.svh"
// =====================================
// permission and gating decisions from the flags
module cfr_access_gate (
  input wire logic [63:0] flags, // current flags
  input wire logic [1:0] current_privilege_level, // current privilege
  input wire logic irq_req, // maskable interrupt request
  input wire logic cr0_am, // alignment mask bit
  input wire logic cr4_supervisor_user_access_prevent, // supervisor access prevention
  input wire logic cr4_vme, // virtual mode extensions
  output logic intr_take, // accept maskable request
  output logic io_ok, // i/o space allowed
  output logic align_chk, // alignment check active
  output logic sup_user_ok, // supervisor to user page allowed
  output logic virt_intr // virtual interrupt deliverable
);
  logic [1:0] io_privilege_level;

  always_comb begin
    io_privilege_level = flags[`CFR_IO_PRIVILEGE_LEVEL_HI:`CFR_IO_PRIVILEGE_LEVEL_LO];
    // RULE_12 interrupt enable gating
    intr_take = irq_req && flags[`CFR_IF_BIT];
    // RULE_13 privilege compare
    io_ok = (current_privilege_level <= io_privilege_level);
    // RULE_18 user alignment check
    align_chk = cr0_am && flags[`CFR_AC_BIT] && (current_privilege_level == `CFR_CPL_USER);
    // RULE_19 supervisor user access
    sup_user_ok = !cr4_supervisor_user_access_prevent || flags[`CFR_AC_BIT];
    // RULE_20 pending bit read only here
    virt_intr = cr4_vme && flags[`CFR_VIF_BIT] && flags[`CFR_VIP_BIT];
  end
endmodule : cfr_access_gate

/* File: rtl/cfr_flags.sv */
// Summary of operation
// RULE_01 - carry flag bit 0 set on carry or borrow out of top bit
// RULE_02 - parity flag bit 2 set when low byte has even ones
// RULE_03 - aux carry bit 4 set on carry or borrow out of bit 3
// RULE_04 - zero flag bit 6 set when whole result is zero
// RULE_05 - sign flag bit 7 copies result top bit
// RULE_06 - overflow bit 11 set on signed out of range result
// RULE_07 - only carry among status flags has set, clear, complement ops
// RULE_08 - bit test copies chosen operand bit into carry
// RULE_09 - add with carry and subtract with borrow use current carry
// RULE_10 - direction bit 10 one steps strings down, zero up
// RULE_11 - set and clear direction ops write one and zero
// RULE_12 - interrupt enable bit 9 gates maskable requests
// RULE_13 - i/o allowed only when privilege level not above field
// RULE_14 - pop and return change privilege field only at level zero
// RULE_15 - nested task bit 14 shows link to previous task
// RULE_16 - resume bit 16 steers debug exception response
// RULE_17 - bit 17 one enables virtual 8086 operation
// RULE_18 - with mask bit set, user alignment check follows bit 18
// RULE_19 - with access prevention on, supervisor user access needs bit 18
// RULE_20 - pending bit 20 written by software only, read with bit 19
// RULE_21 - bit 21 freely writable as feature probe
// RULE_22 - in wide mode register is 64 bits, upper half reserved
// RULE_23 - reset or init loads value with only bit 1 set
// RULE_24 - bits 1, 3, 5, 15, 22 to 31 reserved
// RULE_25 - affected status flags update together, others stay
`timescale 1ns/1ps
`include "cfr_map.svh"
module cfr_flags (
  input wire logic CORE_CLK, // core clock
  input wire logic NRST, // synchronous reset, low
  input wire logic INIT, // init request, loads reset value
  input wire logic MODE_64, // wide mode
  input wire logic OP_VALID, // operation strobe
  input wire cfr_pkg::cfr_op_t OP_CODE, // operation
  input wire cfr_pkg::cfr_size_t OP_SIZE, // operand width
  input wire logic [63:0] OPERAND_A, // first operand
  input wire logic [63:0] OPERAND_B, // second operand
  input wire logic [5:0] BIT_SEL, // bit test index
  input wire logic [63:0] POP_DATA, // pop or return image
  input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL, // current privilege level
  input wire logic IRQ_REQ, // maskable interrupt request
  input wire logic CR0_AM, // alignment mask bit
  input wire logic CR4_SUPERVISOR_USER_ACCESS_PREVENT, // supervisor access prevention
  input wire logic CR4_VME, // virtual mode extensions
  output logic [63:0] FLAGS_OUT, // flags register image
  output logic [63:0] RESULT_OUT, // registered arithmetic result
  output logic STRING_STEP_DOWN, // string address decrements
  output logic SINGLE_STEP, // single step enabled
  output logic INTR_ACCEPT, // maskable request accepted
  output logic IO_ACCESS_OK, // i/o access permitted
  output logic ALIGN_CHECK_EN, // user alignment check on
  output logic SUP_USER_ACCESS_OK, // supervisor to user pages allowed
  output logic NESTED_TASK, // task linked
  output logic RESUME_DEBUG, // debug exceptions held off
  output logic V86_MODE, // virtual 8086 active
  output logic VIRT_INTR_READY // virtual interrupt deliverable
);
  // =====================================
  // state
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [63:0] result_q;
  logic intr_q;
  logic io_ok_q;
  logic align_q;
  logic sup_ok_q;
  logic virt_q;
  logic [31:0] pop_mask;
  logic [31:0] pop_merge;

  // =====================================
  // datapath helpers
  logic [63:0] calc_result;
  logic c_cf;
  logic c_pf;
  logic c_af;
  logic c_zf;
  logic c_sf;
  logic c_of;
  logic g_intr;
  logic g_io;
  logic g_align;
  logic g_sup;
  logic g_virt;
  logic is_arith;

  // =====================================
  // op decode
  // ops that produce a result and status flags
  function automatic logic is_flag_op(input cfr_pkg::cfr_op_t op);
    case (op)
      cfr_pkg::OP_ADD, cfr_pkg::OP_ADC, cfr_pkg::OP_SUB, cfr_pkg::OP_SBB, cfr_pkg::OP_LOGIC: begin
        is_flag_op = 1'b1;
      end
      default: begin
        is_flag_op = 1'b0;
      end
    endcase
  endfunction : is_flag_op

  cfr_status_calc u_calc (
    .op(OP_CODE),
    .size(OP_SIZE),
    .a(OPERAND_A),
    .b(OPERAND_B),
    .carry_in(flags_q[`CFR_CF_BIT]),
    .result(calc_result),
    .cf(c_cf),
    .pf(c_pf),
    .af(c_af),
    .zf(c_zf),
    .sf(c_sf),
    .of(c_of)
  );

  cfr_access_gate u_gate (
    .flags({32'h0, flags_q}),
    .current_privilege_level(CURRENT_PRIVILEGE_LEVEL),
    .irq_req(IRQ_REQ),
    .cr0_am(CR0_AM),
    .cr4_supervisor_user_access_prevent(CR4_SUPERVISOR_USER_ACCESS_PREVENT),
    .cr4_vme(CR4_VME),
    .intr_take(g_intr),
    .io_ok(g_io),
    .align_chk(g_align),
    .sup_user_ok(g_sup),
    .virt_intr(g_virt)
  );

  // =====================================
  // pop and return merge
  always_comb begin
    pop_mask = 32'(`CFR_WRITE_MASK);
    // RULE_14 privilege field guarded
    if (CURRENT_PRIVILEGE_LEVEL != `CFR_CPL_KERNEL) begin
      pop_mask = pop_mask & ~32'(`CFR_IO_PRIVILEGE_LEVEL_MASK);
    end
    // RULE_20 software image carries pending bit
    // RULE_21 probe bit always writable
    pop_merge = (POP_DATA[31:0] & pop_mask) | (flags_q & ~pop_mask);
  end

  // =====================================
  // next flag value
  always_comb begin
    flags_d = flags_q;
    is_arith = is_flag_op(OP_CODE);
    if (OP_VALID) begin
      // RULE_25 status flags together
      if (is_arith) begin
        flags_d[`CFR_CF_BIT] = c_cf;
        flags_d[`CFR_PF_BIT] = c_pf;
        flags_d[`CFR_AF_BIT] = c_af;
        flags_d[`CFR_ZF_BIT] = c_zf;
        flags_d[`CFR_SF_BIT] = c_sf;
        flags_d[`CFR_OF_BIT] = c_of;
      end
      case (OP_CODE)
        // RULE_07 direct carry writes
        cfr_pkg::OP_SET_CARRY: begin
          flags_d[`CFR_CF_BIT] = 1'b1;
        end
        cfr_pkg::OP_CLEAR_CARRY: begin
          flags_d[`CFR_CF_BIT] = 1'b0;
        end
        cfr_pkg::OP_COMPL_CARRY: begin
          flags_d[`CFR_CF_BIT] = ~flags_q[`CFR_CF_BIT];
        end
        // RULE_08 bit test into carry
        cfr_pkg::OP_BIT_TEST: begin
          flags_d[`CFR_CF_BIT] = OPERAND_A[BIT_SEL];
        end
        // RULE_11 direction writes
        cfr_pkg::OP_SET_DIR: begin
          flags_d[`CFR_DF_BIT] = 1'b1;
        end
        cfr_pkg::OP_CLEAR_DIR: begin
          flags_d[`CFR_DF_BIT] = 1'b0;
        end
        // RULE_14 pop and return load
        cfr_pkg::OP_FLAGS_POP, cfr_pkg::OP_INT_RETURN: begin
          flags_d = pop_merge;
        end
        // RULE_15 task link state
        cfr_pkg::OP_TASK_LINK: begin
          flags_d[`CFR_NT_BIT] = 1'b1;
        end
        cfr_pkg::OP_TASK_UNLINK: begin
          flags_d[`CFR_NT_BIT] = 1'b0;
        end
        default: begin
          flags_d = flags_d;
        end
      endcase
    end
    // RULE_24 reserved bits fixed
    flags_d[`CFR_RSV1_BIT] = 1'b1;
    flags_d = flags_d & (32'(`CFR_WRITE_MASK) | (32'h1 << `CFR_RSV1_BIT));
  end

  // =====================================
  // flags register
  always_ff @(posedge CORE_CLK) begin
    // RULE_23 reset and init value
    if (!NRST || INIT) begin
      flags_q <= 32'(`CFR_RESET_VAL);
    end else begin
      flags_q <= flags_d;
    end
  end

  // =====================================
  // result register
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      result_q <= 64'h0;
    end else if (OP_VALID && is_arith) begin
      result_q <= calc_result;
    end
  end

  // =====================================
  // registered gate decisions
  // RULE_12 gated request
  // interrupt accept flop
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      intr_q <= 1'b0;
    end else begin
      intr_q <= g_intr;
    end
  end

  // RULE_13 i/o permission
  // i/o permission flop
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      io_ok_q <= 1'b0;
    end else begin
      io_ok_q <= g_io;
    end
  end

  // RULE_18 alignment check enable
  // alignment check flop
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      align_q <= 1'b0;
    end else begin
      align_q <= g_align;
    end
  end

  // RULE_19 access prevention override
  // supervisor access flop
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      sup_ok_q <= 1'b0;
    end else begin
      sup_ok_q <= g_sup;
    end
  end

  // RULE_20 pending bit only read
  // virtual interrupt flop
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      virt_q <= 1'b0;
    end else begin
      virt_q <= g_virt;
    end
  end

  // =====================================
  // outputs
  // RULE_22 upper half reads zero
  assign FLAGS_OUT = MODE_64 ? {32'h0, flags_q} : {32'h0, flags_q};
  assign RESULT_OUT = result_q;
  // RULE_10 string stepping
  assign STRING_STEP_DOWN = flags_q[`CFR_DF_BIT];
  assign SINGLE_STEP = flags_q[`CFR_TF_BIT];
  assign INTR_ACCEPT = intr_q;
  assign IO_ACCESS_OK = io_ok_q;
  assign ALIGN_CHECK_EN = align_q;
  assign SUP_USER_ACCESS_OK = sup_ok_q;
  // RULE_15 link indication
  assign NESTED_TASK = flags_q[`CFR_NT_BIT];
  // RULE_16 debug response
  assign RESUME_DEBUG = flags_q[`CFR_RF_BIT];
  // RULE_17 virtual 8086 enable
  assign V86_MODE = flags_q[`CFR_VM_BIT];
  assign VIRT_INTR_READY = virt_q;
endmodule : cfr_flags

/* File: verification/cfr_flags_checker.sv */
`timescale 1ns/1ps
// ==========
// flag register checks
module cfr_flags_checker (
  input wire logic CORE_CLK, // clock
  input wire logic NRST, // reset, low
  input wire logic INIT, // init
  input wire logic OP_VALID, // op strobe
  input wire cfr_pkg::cfr_op_t OP_CODE, // op
  input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL, // privilege
  input wire logic IRQ_REQ, // request
  input wire logic [63:0] FLAGS_OUT, // flags
  input wire logic STRING_STEP_DOWN, // step down
  input wire logic INTR_ACCEPT, // request taken
  input wire logic IO_ACCESS_OK // i/o allowed
);
  logic [63:0] prev_q; // flags one edge back
  logic [1:0] cpl_q; // privilege one edge back
  logic irq_q; // request one edge back
  // ==========
  // one edge old copies
  always_ff @(posedge CORE_CLK) begin
    prev_q <= FLAGS_OUT;
    cpl_q <= CURRENT_PRIVILEGE_LEVEL;
    irq_q <= IRQ_REQ;
  end
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // op taken at this edge
  sequence s_take(cfr_pkg::cfr_op_t c);
    OP_VALID && !INIT && OP_CODE == c;
  endsequence
  // image load at a privilege level other than zero
  sequence s_user_pop;
    (s_take(cfr_pkg::OP_FLAGS_POP) or s_take(cfr_pkg::OP_INT_RETURN)) ##0 CURRENT_PRIVILEGE_LEVEL != 2'h0;
  endsequence
  a_init_load: assert property (INIT |=> FLAGS_OUT == 64'h2)
    else $error("init did not load reset flags");
  a_reserved_bits: assert property ((FLAGS_OUT & ~64'h3f7fd7) == 64'h0 && FLAGS_OUT[1])
    else $error("reserved flag bits wrong");
  a_carry_set: assert property (s_take(cfr_pkg::OP_SET_CARRY) |=> FLAGS_OUT[0])
    else $error("carry not set");
  a_carry_flip: assert property (s_take(cfr_pkg::OP_COMPL_CARRY) |=> FLAGS_OUT[0] != prev_q[0])
    else $error("carry not inverted");
  a_dir_set: assert property (s_take(cfr_pkg::OP_SET_DIR) |=> FLAGS_OUT[10] && STRING_STEP_DOWN)
    else $error("direction not set");
  a_pop_io_privilege_level: assert property (s_user_pop |=> FLAGS_OUT[13:12] == prev_q[13:12])
    else $error("privilege field changed");
  a_idle_hold: assert property (!OP_VALID && !INIT |=> FLAGS_OUT == prev_q)
    else $error("flags changed while idle");
  a_intr_gate: assert property ($past(NRST) |-> INTR_ACCEPT == (irq_q && prev_q[9]))
    else $error("request gate wrong");
  a_io_gate: assert property ($past(NRST) |-> IO_ACCESS_OK == (cpl_q <= prev_q[13:12]))
    else $error("i/o gate wrong");
endmodule : cfr_flags_checker

/* File: verification/cfr_op_source.sv */
`timescale 1ns/1ps
// ==========
// issue side model, one op after a chosen lag
module cfr_op_source (
  input wire logic clk, // core clock
  input wire logic start, // new request
  input wire logic [1:0] lag, // idle cycles first
  input wire cfr_pkg::cfr_op_t op_i, // operation
  input wire cfr_pkg::cfr_size_t size_i, // width
  input wire logic [63:0] a_i, // first operand
  input wire logic [63:0] b_i, // second operand
  input wire logic [5:0] sel_i, // bit index
  output logic op_valid, // issue strobe
  output cfr_pkg::cfr_op_t op_code, // issued op
  output cfr_pkg::cfr_size_t op_size, // issued width
  output logic [63:0] operand_a, // issued a
  output logic [63:0] operand_b, // issued b, also image
  output logic [5:0] bit_sel // issued index
);
  logic pend_q; // request waiting
  logic [1:0] wait_q; // lag left
  // idle start
  initial begin
    {op_valid, pend_q, wait_q, operand_a, operand_b, bit_sel} = '0;
    op_code = cfr_pkg::OP_NONE;
    op_size = cfr_pkg::SZ_8;
  end
  // ==========
  // issue timing
  always @(posedge clk) begin
    op_valid <= 1'b0;
    if (start) begin
      pend_q <= lag != 2'h0;
      wait_q <= lag;
      op_valid <= lag == 2'h0;
    end else if (pend_q && wait_q > 2'h1) begin
      wait_q <= wait_q - 2'h1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      op_valid <= 1'b1;
    end
  end
  // operands held, scrambled while idle
  always @(posedge clk) begin
    if (start) begin
      op_code <= op_i;
      op_size <= size_i;
      {operand_a, operand_b, bit_sel} <= {a_i, b_i, sel_i};
    end else if (!pend_q) begin
      {operand_a, operand_b} <= ~{operand_a, operand_b};
    end
  end
endmodule : cfr_op_source

/* File: verification/cfr_flags_tb_top.sv */
`timescale 1ns/1ps
// ==========
// flags register bench
module cfr_flags_tb_top;
  logic CORE_CLK, NRST, INIT, MODE_64, IRQ_REQ, CR0_AM, CR4_SUPERVISOR_USER_ACCESS_PREVENT, CR4_VME, start, OP_VALID;
  logic [1:0] CURRENT_PRIVILEGE_LEVEL, lag_r;
  logic [5:0] sel_r, BIT_SEL;
  cfr_pkg::cfr_op_t op_r, OP_CODE, ro;
  cfr_pkg::cfr_size_t sz_r, OP_SIZE, rs;
  logic [63:0] a_r, b_r, ra, rb, OPERAND_A, OPERAND_B, FLAGS_OUT, RESULT_OUT, exp_f;
  logic STRING_STEP_DOWN, SINGLE_STEP, INTR_ACCEPT, IO_ACCESS_OK, ALIGN_CHECK_EN, SUP_USER_ACCESS_OK;
  logic NESTED_TASK, RESUME_DEBUG, V86_MODE, VIRT_INTR_READY;
  int num_errors = 0;
  int n_compared = 0;
  cfr_flags dut_u (.CORE_CLK(CORE_CLK), .NRST(NRST), .INIT(INIT), .MODE_64(MODE_64), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_SIZE(OP_SIZE), .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B), .BIT_SEL(BIT_SEL),
    .POP_DATA(OPERAND_B), .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .IRQ_REQ(IRQ_REQ), .CR0_AM(CR0_AM), .CR4_SUPERVISOR_USER_ACCESS_PREVENT(CR4_SUPERVISOR_USER_ACCESS_PREVENT), .CR4_VME(CR4_VME),
    .FLAGS_OUT(FLAGS_OUT), .RESULT_OUT(RESULT_OUT), .STRING_STEP_DOWN(STRING_STEP_DOWN), .SINGLE_STEP(SINGLE_STEP),
    .INTR_ACCEPT(INTR_ACCEPT), .IO_ACCESS_OK(IO_ACCESS_OK), .ALIGN_CHECK_EN(ALIGN_CHECK_EN),
    .SUP_USER_ACCESS_OK(SUP_USER_ACCESS_OK), .NESTED_TASK(NESTED_TASK), .RESUME_DEBUG(RESUME_DEBUG),
    .V86_MODE(V86_MODE), .VIRT_INTR_READY(VIRT_INTR_READY));
  cfr_op_source src_u (.clk(CORE_CLK), .start(start), .lag(lag_r), .op_i(op_r), .size_i(sz_r), .a_i(a_r),
    .b_i(b_r), .sel_i(sel_r), .op_valid(OP_VALID), .op_code(OP_CODE), .op_size(OP_SIZE), .operand_a(OPERAND_A),
    .operand_b(OPERAND_B), .bit_sel(BIT_SEL));
  // ==========
  // expected result and status flags {result, of, sf, zf, af, pf, cf}
  function automatic logic [69:0] calc(cfr_pkg::cfr_op_t op, cfr_pkg::cfr_size_t sz, logic [63:0] a, b, logic ci);
    int w;
    logic [64:0] r;
    logic [63:0] m, bb, s;
    logic sb, lg;
    w = 8 << sz;
    m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
    sb = op inside {cfr_pkg::OP_SUB, cfr_pkg::OP_SBB};
    lg = op == cfr_pkg::OP_LOGIC;
    bb = (sb ? ~b : b) & m;
    r = {1'b0, a & m} + {1'b0, bb} + 65'((op inside {cfr_pkg::OP_ADC, cfr_pkg::OP_SBB} && ci) ^ sb);
    s = lg ? a & b & m : r[63:0] & m;
    return {s, !lg && a[w-1] == bb[w-1] && s[w-1] != a[w-1], s[w-1], s == 64'h0, !lg && (a[4] ^ b[4] ^ s[4]),
      ~^s[7:0], !lg && (r[w] ^ sb)};
  endfunction : calc
  // expected flags after one op
  function automatic logic [63:0] upd(logic [63:0] f, cfr_pkg::cfr_op_t op, logic [69:0] v, logic [63:0] a, p,
      logic [5:0] sel, logic [1:0] current_privilege_level);
    logic [63:0] m;
    m = 64'h3f7fd5 & ~((current_privilege_level != 2'h0) ? 64'h3000 : 64'h0);
    case (op)
      cfr_pkg::OP_ADD, cfr_pkg::OP_ADC, cfr_pkg::OP_SUB, cfr_pkg::OP_SBB, cfr_pkg::OP_LOGIC: begin
        {f[11], f[7], f[6], f[4], f[2], f[0]} = v[5:0];
      end
      cfr_pkg::OP_SET_CARRY: f[0] = 1'b1;
      cfr_pkg::OP_CLEAR_CARRY: f[0] = 1'b0;
      cfr_pkg::OP_COMPL_CARRY: f[0] = !f[0];
      cfr_pkg::OP_BIT_TEST: f[0] = a[sel];
      cfr_pkg::OP_SET_DIR: f[10] = 1'b1;
      cfr_pkg::OP_CLEAR_DIR: f[10] = 1'b0;
      cfr_pkg::OP_FLAGS_POP, cfr_pkg::OP_INT_RETURN: f = (f & ~m) | (p & m);
      cfr_pkg::OP_TASK_LINK: f[14] = 1'b1;
      cfr_pkg::OP_TASK_UNLINK: f[14] = 1'b0;
      default: ;
    endcase
    return f;
  endfunction : upd
  // word compare
  task automatic chk_word(logic [63:0] got, logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  // gate and flag output bits compare
  task automatic chk_gate(logic [9:0] got, logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_gate
  // verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // one op through the model, then flags, result of arithmetic and logic ops, and gate outputs
  task automatic do_op(cfr_pkg::cfr_op_t op, cfr_pkg::cfr_size_t sz, logic [63:0] a, b, logic [5:0] sel,
      logic [1:0] current_privilege_level, lag);
    logic [69:0] v;
    @(posedge CORE_CLK);
    start <= 1'b1;
    op_r <= op;
    sz_r <= sz;
    {a_r, b_r, sel_r, lag_r, CURRENT_PRIVILEGE_LEVEL} <= {a, b, sel, lag, current_privilege_level};
    {IRQ_REQ, CR0_AM, CR4_SUPERVISOR_USER_ACCESS_PREVENT, CR4_VME, MODE_64} <= 5'($urandom);
    @(posedge CORE_CLK);
    start <= 1'b0;
    #1;
    for (int i = 0; i < 8 && OP_VALID !== 1'b1; i++) begin
      @(posedge CORE_CLK);
      #1;
    end
    @(posedge CORE_CLK);
    #1;
    v = calc(op, sz, a, b, exp_f[0]);
    exp_f = upd(exp_f, op, v, a, b, sel, current_privilege_level);
    chk_word(FLAGS_OUT, exp_f);
    if (op inside {[cfr_pkg::OP_ADD:cfr_pkg::OP_LOGIC]}) chk_word(RESULT_OUT, v[69:6]);
    @(posedge CORE_CLK);
    #1;
    chk_gate({STRING_STEP_DOWN, SINGLE_STEP, NESTED_TASK, RESUME_DEBUG, V86_MODE, INTR_ACCEPT, IO_ACCESS_OK,
      ALIGN_CHECK_EN, SUP_USER_ACCESS_OK, VIRT_INTR_READY}, {exp_f[10], exp_f[8], exp_f[14], exp_f[16], exp_f[17],
      IRQ_REQ & exp_f[9], CURRENT_PRIVILEGE_LEVEL <= exp_f[13:12], CR0_AM & exp_f[18] & (CURRENT_PRIVILEGE_LEVEL == 2'h3), !CR4_SUPERVISOR_USER_ACCESS_PREVENT | exp_f[18],
      CR4_VME & exp_f[19] & exp_f[20]});
  endtask : do_op
  // ==========
  // clock and watchdog
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {NRST, INIT, MODE_64, IRQ_REQ, CR0_AM, CR4_SUPERVISOR_USER_ACCESS_PREVENT, CR4_VME, start, CURRENT_PRIVILEGE_LEVEL, lag_r, sel_r, a_r, b_r} = '0;
    op_r = cfr_pkg::OP_NONE;
    sz_r = cfr_pkg::SZ_8;
    void'($urandom(32'h55c3));
    repeat (4) @(posedge CORE_CLK);
    NRST <= 1'b1;
    @(posedge CORE_CLK);
    #1;
    exp_f = 64'h2;
    chk_word(FLAGS_OUT, exp_f);
    chk_word(RESULT_OUT, 64'h0);
    do_op(cfr_pkg::OP_ADD, cfr_pkg::SZ_8, 64'hff, 64'h1, 6'h0, 2'h0, 2'h0);
    do_op(cfr_pkg::OP_SUB, cfr_pkg::SZ_16, 64'h0, 64'h1, 6'h0, 2'h1, 2'h3);
    do_op(cfr_pkg::OP_ADD, cfr_pkg::SZ_32, 64'h7fffffff, 64'h1, 6'h0, 2'h0, 2'h0);
    do_op(cfr_pkg::OP_SBB, cfr_pkg::SZ_64, 64'h5, 64'h0, 6'h0, 2'h0, 2'h1);
    do_op(cfr_pkg::OP_ADC, cfr_pkg::SZ_64, '1, 64'h0, 6'h0, 2'h0, 2'h0);
    do_op(cfr_pkg::OP_BIT_TEST, cfr_pkg::SZ_8, 64'h8000000000000000, 64'h0, 6'h3f, 2'h0, 2'h0);
    do_op(cfr_pkg::OP_FLAGS_POP, cfr_pkg::SZ_32, 64'h0, 64'h3000, 6'h0, 2'h3, 2'h2);
    do_op(cfr_pkg::OP_INT_RETURN, cfr_pkg::SZ_32, 64'h0, '1, 6'h0, 2'h0, 2'h0);
    @(posedge CORE_CLK);
    INIT <= 1'b1;
    @(posedge CORE_CLK);
    INIT <= 1'b0;
    #1;
    exp_f = 64'h2;
    chk_word(FLAGS_OUT, exp_f);
    for (int k = 0; k < 216; k++) begin
      ro = cfr_pkg::cfr_op_t'(5'(k < 16 ? k : $urandom_range(17, 0)));
      rs = cfr_pkg::cfr_size_t'(2'($urandom));
      ra = {$urandom, $urandom};
      rb = {$urandom, $urandom};
      do_op(ro, rs, ra, rb, 6'($urandom), 2'($urandom), 2'($urandom));
    end
    report_and_stop();
  end
endmodule : cfr_flags_tb_top
bind cfr_flags cfr_flags_checker chk_u (.CORE_CLK(CORE_CLK), .NRST(NRST), .INIT(INIT), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .IRQ_REQ(IRQ_REQ), .FLAGS_OUT(FLAGS_OUT), .STRING_STEP_DOWN(STRING_STEP_DOWN),
  .INTR_ACCEPT(INTR_ACCEPT), .IO_ACCESS_OK(IO_ACCESS_OK));
